// ===== pkg/flash_cmd_regs.svh
// Purpose: offsets, field positions, reset values and codes of the flash command block
// Assumes: 32-bit register bus, one aligned word per register
// Notes: narrow registers sit in the low bits, upper bits read zero
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_STATUS 8'h00
`define OFS_COMMAND 8'h04
`define OFS_ADDR 8'h08
`define OFS_DATA 8'h0C
`define OFS_IRQ_STAT 8'h10
`define OFS_IRQ_MASK 8'h14

// ----------------------------------------------------------------
// status field positions and reset value
// ----------------------------------------------------------------
`define BIT_CBEF 7
`define BIT_CCF 6
`define BIT_PVIOL 5
`define BIT_ACCERR 4
`define BIT_BLANK 2
`define STATUS_RESET 8'hC0
`define COMMAND_RESET 8'h00

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_BLANK_CHECK 8'h05
`define CMD_BYTE_PROGRAM 8'h20
`define CMD_BURST_PROGRAM 8'h25
`define CMD_PAGE_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41

// ----------------------------------------------------------------
// interrupt status / mask layout
// ----------------------------------------------------------------
`define IRQ_W 3
`define IRQ_BIT_DONE 0
`define IRQ_BIT_PVIOL 1
`define IRQ_BIT_ACCERR 2
`define IRQ_MASK_RESET 3'h0

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== pkg/flash_cmd_pkg.sv
// Purpose: shared types of the flash command block
// Assumes: constants come from flash_cmd_regs.svh
// Notes: none
package flash_cmd_pkg;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_RUN} seq_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic [15:0] addr;
    logic [7:0] data;
  } cmd_item_t;

  typedef struct packed {
    logic legal;
    logic burst;
    logic prog_erase;
    logic blank;
  } cmd_class_t;

endpackage : flash_cmd_pkg

// ===== design/flash_cmd_decode.sv
// Purpose: classify a command code
// Assumes: code is stable while read
// Notes: purely combinational
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"
module flash_cmd_decode
  import flash_cmd_pkg::*;
(
  input wire logic [7:0] code,
  output cmd_class_t cls
);

  always_comb
  begin
    cls = '0;
    unique case (code)
      `CMD_BLANK_CHECK:
      begin
        cls.legal = 1'b1;
        cls.blank = 1'b1;
      end
      `CMD_BYTE_PROGRAM, `CMD_PAGE_ERASE, `CMD_MASS_ERASE:
      begin
        cls.legal = 1'b1;
        cls.prog_erase = 1'b1;
      end
      `CMD_BURST_PROGRAM:
      begin
        cls.legal = 1'b1;
        cls.prog_erase = 1'b1;
        cls.burst = 1'b1;
      end
      default:
      begin
        cls = '0;
      end
    endcase
  end

endmodule : flash_cmd_decode

// ===== design/irq_sticky.sv
// Purpose: sticky event bits, read-to-clear, masked onto one level interrupt
// Assumes: set and clr are one-cycle pulses on core_clk
// Notes: a set in the clearing cycle survives
`timescale 1ns/100ps
module irq_sticky #(
  parameter int W = 3
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic clr,
  input wire logic [W-1:0] mask,
  output logic [W-1:0] status,
  output logic irq
);

  logic [W-1:0] next_status;

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    always_comb
    begin
      next_status[i] = set[i] | (status[i] & ~clr);
    end
    always_ff @(posedge core_clk or negedge rst_n)
    begin
      if (!rst_n)
        status[i] <= 1'b0;
      else
        status[i] <= next_status[i];
    end
  end

  assign irq = |(status & mask);

endmodule : irq_sticky

// ===== design/flash_command_status_interface.sv
// Purpose: flash command launch and status flags behind an AXI4-Lite slave
// Assumes: array, protection and divider logic run on core_clk
// Notes: one command executes, one burst program may wait behind it
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"
module flash_command_status_interface
  import flash_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic div_ready,
  input wire logic stop_mode,
  output logic [15:0] protect_addr,
  input wire logic protect_hit,
  output logic array_start,
  output cmd_item_t array_item,
  output logic array_abort,
  input wire logic array_done,
  input wire logic array_blank
);

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic [7:0] next_aw_addr;
  logic next_w_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic wr_fire;
  logic rd_fire;
  logic wr_mapped;
  logic rd_mapped;
  logic irq_rd_clr;
  logic clr_pviol;
  logic clr_accerr;

  // ----------------------------------------------------------------
  // command and status state
  // ----------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic cbef;
  logic ccf;
  logic pviol;
  logic accerr;
  logic blank;
  logic cmd_loaded;
  logic queued;
  logic [7:0] cmd_code;
  logic [15:0] cmd_addr;
  logic [7:0] cmd_data;
  cmd_item_t queue_item;
  logic [2:0] irq_mask;
  logic next_cbef;
  logic next_ccf;
  logic next_pviol;
  logic next_accerr;
  logic next_blank;
  logic next_cmd_loaded;
  logic next_queued;
  logic [7:0] next_cmd_code;
  logic [15:0] next_cmd_addr;
  logic [7:0] next_cmd_data;
  cmd_item_t next_queue_item;
  cmd_item_t next_array_item;
  logic next_array_start;
  logic next_array_abort;
  logic [2:0] next_irq_mask;
  logic [2:0] irq_set;
  logic [2:0] irq_status;
  logic [7:0] status_rd;
  cmd_class_t new_cls;
  cmd_class_t cur_cls;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign irq_rd_clr = rd_fire && (s_axi_araddr == `OFS_IRQ_STAT);
  assign clr_pviol = wr_fire && w_strb[0] && aw_addr == `OFS_STATUS && w_data[`BIT_PVIOL];
  assign clr_accerr = wr_fire && w_strb[0] && aw_addr == `OFS_STATUS && w_data[`BIT_ACCERR];
  assign protect_addr = cmd_addr;
  // unused bit positions are constant zero
  assign status_rd = {cbef, ccf, pviol, accerr, 1'b0, blank, 2'b00};

  flash_cmd_decode u_new_decode (
    .code(cmd_code),
    .cls(new_cls)
  );

  flash_cmd_decode u_cur_decode (
    .code(array_item.code),
    .cls(cur_cls)
  );

  irq_sticky #(
    .W(`IRQ_W)
  ) u_irq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set(irq_set),
    .clr(irq_rd_clr),
    .mask(irq_mask),
    .status(irq_status),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // bus handshakes and read data
  // ----------------------------------------------------------------
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    wr_mapped = aw_addr == `OFS_STATUS || aw_addr == `OFS_COMMAND ||
      aw_addr == `OFS_ADDR || aw_addr == `OFS_DATA ||
      aw_addr == `OFS_IRQ_STAT || aw_addr == `OFS_IRQ_MASK;
    rd_mapped = 1'b1;
    if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (rd_fire)
    begin
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        `OFS_STATUS: next_rdata[7:0] = status_rd;
        `OFS_ADDR: next_rdata[15:0] = cmd_addr;
        `OFS_DATA: next_rdata[7:0] = cmd_data;
        `OFS_IRQ_STAT: next_rdata[2:0] = irq_status;
        `OFS_IRQ_MASK: next_rdata[2:0] = irq_mask;
        `OFS_COMMAND: next_rdata[7:0] = 8'h00;
        default: rd_mapped = 1'b0;
      endcase
      next_rresp = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // command sequencer and status flags
  // ----------------------------------------------------------------
  // hardware sets are applied after software clears so a set always wins
  always_comb
  begin
    next_state = state;
    next_cbef = cbef;
    next_pviol = pviol;
    next_accerr = accerr;
    next_blank = blank;
    next_cmd_loaded = cmd_loaded;
    next_queued = queued;
    next_cmd_code = cmd_code;
    next_cmd_addr = cmd_addr;
    next_cmd_data = cmd_data;
    next_queue_item = queue_item;
    next_array_item = array_item;
    next_array_start = 1'b0;
    next_array_abort = 1'b0;
    next_irq_mask = irq_mask;
    irq_set = '0;
    // finished command: queued burst moves in, otherwise go idle
    if (state == SEQ_RUN && array_done)
    begin
      if (cur_cls.blank && array_blank)
        next_blank = 1'b1;
      next_state = SEQ_IDLE;
    end
    // register writes; writes to complete and blank bits have no effect
    if (wr_fire && w_strb[0])
    begin
      unique case (aw_addr)
        `OFS_STATUS:
        begin
          if (w_data[`BIT_PVIOL])
            next_pviol = 1'b0;
          if (w_data[`BIT_ACCERR])
            next_accerr = 1'b0;
          if (w_data[`BIT_CBEF] && cbef)
          begin
            next_cmd_loaded = 1'b0;
            if (!cmd_loaded || !new_cls.legal)
              next_accerr = 1'b1;
            else if (new_cls.prog_erase && !div_ready)
              next_accerr = 1'b1;
            else if (state == SEQ_RUN && !(new_cls.burst && cur_cls.burst))
              next_accerr = 1'b1;
            else if (new_cls.prog_erase && protect_hit)
              next_pviol = 1'b1;
            else
            begin
              next_cbef = 1'b0;
              next_blank = 1'b0;
              next_queued = 1'b1;
              next_queue_item = '{code: cmd_code, addr: cmd_addr, data: cmd_data};
            end
          end
        end
        `OFS_COMMAND:
        begin
          if (cbef)
          begin
            next_cmd_code = w_data[7:0];
            next_cmd_loaded = 1'b1;
          end
          else
            next_accerr = 1'b1;
        end
        `OFS_ADDR:
        begin
          next_cmd_addr[7:0] = w_data[7:0];
          if (w_strb[1])
            next_cmd_addr[15:8] = w_data[15:8];
        end
        `OFS_DATA: next_cmd_data = w_data[7:0];
        `OFS_IRQ_MASK: next_irq_mask = w_data[2:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // move the buffered command into the array; buffer is empty again
    if (queued && (state == SEQ_IDLE || array_done))
    begin
      next_array_item = queue_item;
      next_array_start = 1'b1;
      next_state = SEQ_RUN;
      next_queued = 1'b0;
      next_cbef = 1'b1;
    end
    // stop mode kills the running and the buffered command
    if (stop_mode && (state == SEQ_RUN || queued))
    begin
      next_accerr = 1'b1;
      next_array_abort = state == SEQ_RUN;
      next_array_start = 1'b0;
      next_state = SEQ_IDLE;
      next_queued = 1'b0;
      next_cbef = 1'b1;
    end
    next_ccf = next_cbef && !next_queued && next_state == SEQ_IDLE;
    irq_set[`IRQ_BIT_DONE] = next_ccf && !ccf;
    // an error that recurs while software clears its flag is still a new event
    irq_set[`IRQ_BIT_PVIOL] = next_pviol && !(pviol && !clr_pviol);
    irq_set[`IRQ_BIT_ACCERR] = next_accerr && !(accerr && !clr_accerr);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= SEQ_IDLE;
      cbef <= 1'b1;
      ccf <= 1'b1;
      pviol <= 1'b0;
      accerr <= 1'b0;
      blank <= 1'b0;
      cmd_loaded <= 1'b0;
      queued <= 1'b0;
      cmd_code <= `COMMAND_RESET;
      cmd_addr <= 16'h0000;
      cmd_data <= 8'h00;
      queue_item <= '0;
      array_item <= '0;
      array_start <= 1'b0;
      array_abort <= 1'b0;
      irq_mask <= `IRQ_MASK_RESET;
    end
    else
    begin
      state <= next_state;
      cbef <= next_cbef;
      ccf <= next_ccf;
      pviol <= next_pviol;
      accerr <= next_accerr;
      blank <= next_blank;
      cmd_loaded <= next_cmd_loaded;
      queued <= next_queued;
      cmd_code <= next_cmd_code;
      cmd_addr <= next_cmd_addr;
      cmd_data <= next_cmd_data;
      queue_item <= next_queue_item;
      array_item <= next_array_item;
      array_start <= next_array_start;
      array_abort <= next_array_abort;
      irq_mask <= next_irq_mask;
    end
  end

endmodule : flash_command_status_interface

// ===== tb/flash_cmd_sva.sv
// Purpose: port-level checks of the flash command block
// Assumes: one clock, rst_n asynchronous and active low
// Notes: busy state is rebuilt from the array start/done/abort ports
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"
module flash_cmd_sva
  import flash_cmd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic stop_mode,
  input wire logic array_start,
  input wire cmd_item_t array_item,
  input wire logic array_abort,
  input wire logic array_done
);
  logic running;
  logic next_running;

  always_comb
  begin
    next_running = running;
    if (array_start)
      next_running = 1'b1;
    else if (array_done || array_abort)
      next_running = 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      running <= 1'b0;
    else
      running <= next_running;
  end

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence rd_req(logic [7:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence

  status_reserved_a: assert property (rd_req(`OFS_STATUS) |=>
    s_axi_rvalid && (s_axi_rdata & 32'hFFFFFF0B) == 32'h0) else $error("status spare bits set");
  busy_complete_a: assert property ((running && !array_abort) ##0 rd_req(`OFS_STATUS) |=>
    !s_axi_rdata[6]) else $error("complete flag high while busy");
  cmd_reads_zero_a: assert property (rd_req(`OFS_COMMAND) |=>
    s_axi_rvalid && s_axi_rdata == 32'h0) else $error("command register read not zero");
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h17
    |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  start_pulse_a: assert property (array_start |=> !array_start)
    else $error("start longer than one cycle");
  start_idle_a: assert property (array_start |-> !running)
    else $error("start while array busy");
  item_stable_a: assert property ($changed(array_item) |-> array_start)
    else $error("item changed without start");
  stop_abort_a: assert property (running && stop_mode |-> ##[0:2] array_abort)
    else $error("stop did not abort");
  abort_busy_a: assert property (array_abort |-> running)
    else $error("abort while idle");
endmodule : flash_cmd_sva

bind flash_command_status_interface flash_cmd_sva chk (
  .core_clk(core_clk), .rst_n(rst_n), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .stop_mode(stop_mode),
  .array_start(array_start), .array_item(array_item), .array_abort(array_abort),
  .array_done(array_done)
);

// ===== tb/flash_command_status_interface_tb.sv
// Purpose: self-checking bench of the flash command block
// Assumes: AXI4-Lite master tasks below, array side played here
// Notes: protection answer is derived from address bit 15
`timescale 1ns/100ps
`include "flash_cmd_regs.svh"
module flash_command_status_interface_tb
  import flash_cmd_pkg::*;
;
  logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, irq, div_ready, stop_mode, protect_hit, array_start;
  logic array_abort, array_done, array_blank, bl;
  logic [7:0] s_axi_awaddr, s_axi_araddr, dat, code, bad;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [15:0] protect_addr, adr;
  cmd_item_t array_item;
  int fails, n_compared, n_start, cyc, es;
  logic [7:0] codes [5];

  flash_command_status_interface uut (
    .core_clk(core_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq),
    .div_ready(div_ready), .stop_mode(stop_mode), .protect_addr(protect_addr),
    .protect_hit(protect_hit), .array_start(array_start), .array_item(array_item),
    .array_abort(array_abort), .array_done(array_done), .array_blank(array_blank)
  );

  // upper half of the array is the protected block
  assign protect_hit = protect_addr[15];

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (array_start === 1'b1)
      n_start <= n_start + 1;
    if (cyc == 5000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  task automatic st(input logic [7:0] e);
    rdr(`OFS_STATUS);
    chk("status", rd, {24'h0, e});
  endtask : st

  task automatic launch(input logic [7:0] c, input logic [15:0] a);
    adr = a;
    dat = 8'($urandom);
    wr(`OFS_ADDR, {16'h0, a});
    wr(`OFS_DATA, {24'h0, dat});
    wr(`OFS_COMMAND, {24'h0, c});
    wr(`OFS_STATUS, 32'h80);
    repeat (4) @(posedge core_clk);
  endtask : launch

  task automatic finish(input logic b);
    @(posedge core_clk);
    array_done <= 1'b1;
    array_blank <= b;
    @(posedge core_clk);
    array_done <= 1'b0;
  endtask : finish

  function automatic bit legal(input logic [7:0] c);
    return c inside {codes};
  endfunction : legal

  function automatic logic [7:0] exp_done(input logic [7:0] c, input logic b);
    return (c == `CMD_BLANK_CHECK && b) ? 8'hC4 : 8'hC0;
  endfunction : exp_done

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {stop_mode, array_done, array_blank, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {fails, n_compared, n_start, cyc, es} = '0;
    div_ready = 1'b1;
    s_axi_wstrb = 4'hF;
    codes = '{`CMD_BLANK_CHECK, `CMD_BYTE_PROGRAM, `CMD_BURST_PROGRAM,
      `CMD_PAGE_ERASE, `CMD_MASS_ERASE};
    void'($urandom(96));
    do bad = 8'($urandom); while (legal(bad));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    st(8'hC0);
    rdr(`OFS_COMMAND);
    chk("command", rd, 32'h0);
    rdr(8'h1C);
    chk("unmapped", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(8'h1C, 32'h0);
    chk("unmapped write", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    wr(`OFS_STATUS, 32'h4F);
    chk("write resp", {30'h0, rsp}, {30'h0, `RESP_OKAY});
    st(8'hC0);
    wr(`OFS_STATUS, 32'h80);
    st(8'hD0);
    wr(`OFS_STATUS, 32'h00);
    st(8'hD0);
    wr(`OFS_STATUS, 32'h10);
    st(8'hC0);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      code = (i < 5) ? codes[i] : bad;
      bl = (i == 0) | 1'($urandom);
      launch(code, {1'b0, 15'($urandom)});
      es += int'(legal(code));
      chk("starts", n_start, es);
      if (legal(code))
      begin
        chk("item", array_item, {code, adr, dat});
        st(8'h80);
        finish(bl);
        st(exp_done(code, bl));
      end
      else
      begin
        st(8'hD0);
        wr(`OFS_STATUS, 32'h10);
      end
    end
    $display("test commands done");
    launch(`CMD_BYTE_PROGRAM, {1'b1, 15'($urandom)});
    st(8'hE0);
    wr(`OFS_STATUS, 32'h10);
    st(8'hE0);
    wr(`OFS_STATUS, 32'h20);
    st(8'hC0);
    div_ready <= 1'b0;
    launch(`CMD_PAGE_ERASE, 16'h0200);
    st(8'hD0);
    div_ready <= 1'b1;
    chk("starts", n_start, es);
    wr(`OFS_STATUS, 32'h10);
    $display("test refusals done");
    // a waiting burst holds the buffer full until the running one ends
    launch(`CMD_BURST_PROGRAM, 16'h0123);
    launch(`CMD_BYTE_PROGRAM, 16'h0124);
    st(8'h90);
    wr(`OFS_STATUS, 32'h10);
    launch(`CMD_BURST_PROGRAM, 16'h0125);
    st(8'h00);
    wr(`OFS_COMMAND, {24'h0, `CMD_BURST_PROGRAM});
    st(8'h10);
    finish(1'b0);
    st(8'h90);
    chk("starts", n_start, es + 2);
    finish(1'b0);
    st(8'hD0);
    wr(`OFS_STATUS, 32'h10);
    launch(`CMD_MASS_ERASE, 16'h0010);
    stop_mode <= 1'b1;
    @(posedge core_clk);
    stop_mode <= 1'b0;
    st(8'hD0);
    $display("test burst and stop done");
    wr(`OFS_IRQ_MASK, 32'h4);
    chk("irq", {31'h0, irq}, 32'h1);
    rdr(`OFS_IRQ_STAT);
    chk("irq status", rd, 32'h7);
    repeat (2) @(posedge core_clk);
    chk("irq", {31'h0, irq}, 32'h0);
    wr(`OFS_STATUS, 32'h90);
    repeat (2) @(posedge core_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    rdr(`OFS_IRQ_STAT);
    chk("irq status", rd, 32'h4);
    $display("test interrupt done");
    give_verdict();
  end
endmodule : flash_command_status_interface_tb
